// >>> tcr_defs.svh
/*
 Offsets, field positions, reset values and widths of the timer
 capture/compare register slice.
 Assumes byte-wide register access over port-instruction and data-space addresses.
*/
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

`define TCR_TIMER_W 16
`define TCR_BYTE_W 8
`define TCR_RESET_BYTE 8'h00

// Port-instruction range and data-space displacement
`define TCR_IO_LIMIT 8'h3F
`define TCR_IO_TO_DATA 8'h20
`define TCR_EXT_BASE 8'h60

// Low I/O registers, as I/O offsets
`define TCR_CAP1_LO_IO 8'h26
`define TCR_CAP1_HI_IO 8'h27
`define TCR_FLAG_IO 8'h36
`define TCR_MASK_IO 8'h37

// Extended registers, data space only
`define TCR_CAP3_LO 8'h80
`define TCR_CAP3_HI 8'h81
`define TCR_CMP3C_LO 8'h82
`define TCR_CMP3C_HI 8'h83
`define TCR_CMP3B_LO 8'h84
`define TCR_CMP3B_HI 8'h85
`define TCR_CMP3A_LO 8'h86
`define TCR_CMP3A_HI 8'h87

// Mask and flag fields
`define TCR_MASK_LSB 2
`define TCR_MASK_MSB 5
`define TCR_CAP_BIT 5
`define TCR_CMPA_BIT 4
`define TCR_CMPB_BIT 3
`define TCR_OVF_BIT 2

`endif

// >>> tcr_pkg.sv
/*
 Types of the timer capture/compare register slice.
 Assumes tcr_defs.svh is on the include path.
*/
`include "tcr_defs.svh"

package tcr_pkg;

   typedef logic [`TCR_TIMER_W-1:0] tcr_word_t;
   typedef logic [`TCR_BYTE_W-1:0] tcr_byte_t;

   // Capture unit state
   typedef struct packed {
      logic pin_s1;
      logic pin_s2;
      logic comp_s1;
      logic comp_s2;
      logic prev;
      logic event_pulse;
   } tcr_unit_s;

   // Register slice state
   typedef struct packed {
      tcr_word_t cap1;
      tcr_word_t cap3;
      tcr_word_t cmp3a;
      tcr_word_t cmp3b;
      tcr_word_t cmp3c;
      tcr_byte_t hold;
      logic [`TCR_MASK_MSB:`TCR_MASK_LSB] mask;
      logic cap_flag;
      logic irq_cap;
      logic irq_cmpa;
      logic irq_cmpb;
      logic irq_ovf;
      tcr_byte_t rdata;
   } tcr_state_s;

endpackage

// >>> tcr_event_if.sv
/*
 Carrier between the register slice and one capture unit.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

interface tcr_event_if;
   logic use_comp;
   logic edge_rise;
   logic event_pulse;

   modport unit (
      input use_comp,
      input edge_rise,
      output event_pulse
   );
   modport core (
      output use_comp,
      output edge_rise,
      input event_pulse
   );
endinterface

`default_nettype wire

// >>> tcr_capture_unit.sv
/*
 One capture event detector: synchronises the capture pin and the
 comparator output, picks the source and flags the chosen edge.
 Assumes both inputs are asynchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tcr_capture_unit (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic cap_pin,
   input wire logic comp_in,
   tcr_event_if.unit evt
);

   tcr_pkg::tcr_unit_s s_reg;
   tcr_pkg::tcr_unit_s s_next;
   logic src;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.pin_s1 = cap_pin;
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.comp_s1 = comp_in;
      s_next.comp_s2 = s_reg.comp_s1;
      // Source switch can fake one edge; software should discard it
      src = evt.use_comp ? s_reg.comp_s2 : s_reg.pin_s2;
      s_next.prev = src;
      s_next.event_pulse = (src != s_reg.prev) &&
         (src == evt.edge_rise);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign evt.event_pulse = s_reg.event_pulse;

endmodule // tcr_capture_unit

`default_nettype wire

// >>> tcr_capture_compare.sv
/*
 Register slice of two 16-bit timers: capture registers of both,
 three compare values of the second, interrupt mask of the first,
 the shared high-byte latch and the first capture flag.
 Assumes the counters, waveform modes and other flags live outside,
 all on core_clk, and that reads and writes never share a cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tcr_defs.svh"

module tcr_capture_compare #(
   parameter int TIMER_W = `TCR_TIMER_W
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] bus_addr,
   input wire logic bus_io_space,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic [1:0] capture_input_pin,
   input wire logic analog_comp_out,
   input wire logic first_capture_src_comp,
   input wire logic [1:0] capture_edge_rising,
   input wire logic [1:0] capture_is_top,
   input wire logic [1:0] counter_at_top,
   input wire logic [TIMER_W-1:0] first_running_counter_value,
   input wire logic [TIMER_W-1:0] second_running_counter_value,
   input wire logic global_irq_enable,
   input wire logic first_capture_irq_ack,
   input wire logic first_compare_a_flag,
   input wire logic first_compare_b_flag,
   input wire logic first_overflow_flag,
   output logic first_capture_flag,
   output logic first_capture_irq,
   output logic first_compare_a_irq,
   output logic first_compare_b_irq,
   output logic first_overflow_irq,
   output logic [TIMER_W-1:0] first_timer_capture_value,
   output logic [TIMER_W-1:0] second_timer_capture_value,
   output logic [TIMER_W-1:0] second_timer_compare_a,
   output logic [TIMER_W-1:0] second_timer_compare_b,
   output logic [TIMER_W-1:0] second_timer_compare_c
);

   ////////////////////////////////////////////////////////////////////
   // Elaboration check
   generate
      if (TIMER_W != `TCR_TIMER_W) begin : g_bad_width
         $error("tcr_capture_compare: timer width must be two bytes");
      end
   endgenerate

   tcr_pkg::tcr_state_s s_reg;
   tcr_pkg::tcr_state_s s_next;
   logic [1:0] cap_event;
   logic io_ok;
   logic [7:0] data_addr;
   logic cap_set;
   logic cap_clr;

   ////////////////////////////////////////////////////////////////////
   // Capture event detectors, one per timer
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_unit
         tcr_event_if evt_if ();

         if (gi == 0) begin : g_first
            assign evt_if.use_comp = first_capture_src_comp;
         end else begin : g_second
            assign evt_if.use_comp = 1'b0;
         end
         assign evt_if.edge_rise = capture_edge_rising[gi];
         assign cap_event[gi] = evt_if.event_pulse;

         tcr_capture_unit u_unit (
            .core_clk(core_clk),
            .srst(srst),
            .cap_pin(capture_input_pin[gi]),
            .comp_in(analog_comp_out),
            .evt(evt_if)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Address translation
   always_comb begin
      // Port-instruction offsets above the low range are dropped
      io_ok = !bus_io_space || (bus_addr <= `TCR_IO_LIMIT);
      // Port offsets map onto data space; extended range unreachable
      data_addr = bus_io_space ? 8'(bus_addr + `TCR_IO_TO_DATA)
         : bus_addr;
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.rdata = `TCR_RESET_BYTE;
      cap_clr = 1'b0;

      // Reads: low byte also loads the shared latch
      if (bus_rd && io_ok) begin
         case (data_addr)
            8'(`TCR_CAP1_LO_IO + `TCR_IO_TO_DATA): begin
               s_next.rdata = s_reg.cap1[7:0];
               s_next.hold = s_reg.cap1[15:8];
            end
            8'(`TCR_CAP1_HI_IO + `TCR_IO_TO_DATA): begin
               s_next.rdata = s_reg.hold;
            end
            `TCR_CAP3_LO: begin
               s_next.rdata = s_reg.cap3[7:0];
               s_next.hold = s_reg.cap3[15:8];
            end
            `TCR_CMP3C_LO: begin
               s_next.rdata = s_reg.cmp3c[7:0];
               s_next.hold = s_reg.cmp3c[15:8];
            end
            `TCR_CMP3B_LO: begin
               s_next.rdata = s_reg.cmp3b[7:0];
               s_next.hold = s_reg.cmp3b[15:8];
            end
            `TCR_CMP3A_LO: begin
               s_next.rdata = s_reg.cmp3a[7:0];
               s_next.hold = s_reg.cmp3a[15:8];
            end
            `TCR_CAP3_HI, `TCR_CMP3C_HI, `TCR_CMP3B_HI,
            `TCR_CMP3A_HI: begin
               s_next.rdata = s_reg.hold;
            end
            8'(`TCR_MASK_IO + `TCR_IO_TO_DATA): begin
               s_next.rdata = `TCR_RESET_BYTE;
               s_next.rdata[`TCR_MASK_MSB:`TCR_MASK_LSB] = s_reg.mask;
            end
            8'(`TCR_FLAG_IO + `TCR_IO_TO_DATA): begin
               s_next.rdata = `TCR_RESET_BYTE;
               s_next.rdata[`TCR_CAP_BIT] = s_reg.cap_flag;
            end
            default: begin
               s_next.rdata = `TCR_RESET_BYTE;
            end
         endcase
      end

      // Writes: high byte stages in the latch, low byte commits both
      if (bus_wr && io_ok) begin
         case (data_addr)
            8'(`TCR_CAP1_LO_IO + `TCR_IO_TO_DATA): begin
               s_next.cap1 = {s_reg.hold, bus_wdata};
            end
            `TCR_CAP3_LO: begin
               s_next.cap3 = {s_reg.hold, bus_wdata};
            end
            `TCR_CMP3C_LO: begin
               s_next.cmp3c = {s_reg.hold, bus_wdata};
            end
            `TCR_CMP3B_LO: begin
               s_next.cmp3b = {s_reg.hold, bus_wdata};
            end
            `TCR_CMP3A_LO: begin
               s_next.cmp3a = {s_reg.hold, bus_wdata};
            end
            8'(`TCR_CAP1_HI_IO + `TCR_IO_TO_DATA), `TCR_CAP3_HI,
            `TCR_CMP3C_HI, `TCR_CMP3B_HI, `TCR_CMP3A_HI: begin
               s_next.hold = bus_wdata;
            end
            8'(`TCR_MASK_IO + `TCR_IO_TO_DATA): begin
               s_next.mask = bus_wdata[`TCR_MASK_MSB:`TCR_MASK_LSB];
            end
            8'(`TCR_FLAG_IO + `TCR_IO_TO_DATA): begin
               cap_clr = bus_wdata[`TCR_CAP_BIT];
            end
            default: begin
               cap_clr = 1'b0;
            end
         endcase
      end

      // Pin capture wins over a same-cycle software write; in top
      // mode the register holds the top value and is not overwritten
      if (cap_event[0] && !capture_is_top[0]) begin
         s_next.cap1 = first_running_counter_value;
      end
      if (cap_event[1] && !capture_is_top[1]) begin
         s_next.cap3 = second_running_counter_value;
      end

      // Flag source follows the mode; a set beats a clear
      cap_set = capture_is_top[0] ? counter_at_top[0]
         : cap_event[0];
      if (cap_clr || first_capture_irq_ack) begin
         s_next.cap_flag = 1'b0;
      end
      if (cap_set) begin
         s_next.cap_flag = 1'b1;
      end

      // Capture request registered in step with its flag; the other requests one cycle after their input flags
      s_next.irq_cap = global_irq_enable &&
         s_next.mask[`TCR_CAP_BIT] && s_next.cap_flag;
      s_next.irq_cmpa = global_irq_enable &&
         s_next.mask[`TCR_CMPA_BIT] && first_compare_a_flag;
      s_next.irq_cmpb = global_irq_enable &&
         s_next.mask[`TCR_CMPB_BIT] && first_compare_b_flag;
      s_next.irq_ovf = global_irq_enable &&
         s_next.mask[`TCR_OVF_BIT] && first_overflow_flag;
   end

   ////////////////////////////////////////////////////////////////////
   // State register; every field resets to zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register
   assign bus_rdata = s_reg.rdata;
   assign first_capture_flag = s_reg.cap_flag;
   assign first_capture_irq = s_reg.irq_cap;
   assign first_compare_a_irq = s_reg.irq_cmpa;
   assign first_compare_b_irq = s_reg.irq_cmpb;
   assign first_overflow_irq = s_reg.irq_ovf;
   // Capture register doubles as the counter top value
   assign first_timer_capture_value = s_reg.cap1;
   assign second_timer_capture_value = s_reg.cap3;
   assign second_timer_compare_a = s_reg.cmp3a;
   assign second_timer_compare_b = s_reg.cmp3b;
   assign second_timer_compare_c = s_reg.cmp3c;

endmodule // tcr_capture_compare

`default_nettype wire

// >>> tcr_capture_compare_chk.sv
/*
 Port-level assertions for the timer capture/compare register slice.
 Assumes it is bound into tcr_capture_compare, all on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module tcr_capture_compare_chk #(
   parameter int TIMER_W = 16
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] bus_addr,
   input wire logic bus_io_space,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic [1:0] capture_input_pin,
   input wire logic first_capture_src_comp,
   input wire logic [1:0] capture_edge_rising,
   input wire logic [1:0] capture_is_top,
   input wire logic [1:0] counter_at_top,
   input wire logic global_irq_enable,
   input wire logic first_capture_irq_ack,
   input wire logic first_compare_a_flag,
   input wire logic first_capture_flag,
   input wire logic first_capture_irq,
   input wire logic first_compare_a_irq,
   input wire logic [TIMER_W-1:0] first_timer_capture_value,
   input wire logic [TIMER_W-1:0] second_timer_compare_a,
   input wire logic [TIMER_W-1:0] second_timer_compare_b
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   sequence s_wr(logic [7:0] a);
      bus_wr && !bus_io_space && bus_addr == a;
   endsequence
   sequence s_quiet;
      $stable(capture_input_pin[0]) [*4];
   endsequence
   sequence s_edge1;
      $rose(capture_input_pin[0]) && capture_edge_rising[0] &&
         !first_capture_src_comp && !capture_is_top[0];
   endsequence
   // High byte staged, low byte commits both halves at once
   property p_pair(logic [7:0] ha, logic [15:0] v);
      s_wr(ha) ##1 s_wr(ha - 8'h01) |=>
         v == {$past(bus_wdata, 2), $past(bus_wdata)};
   endproperty
   ////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (
      !bus_rd |=> bus_rdata == 8'h00) else $error("read data not idle");
   a_cmpa_pair: assert property (
      p_pair(8'h87, second_timer_compare_a)) else $error("compare a pair");
   a_cmpb_pair: assert property (
      p_pair(8'h85, second_timer_compare_b)) else $error("compare b pair");
   a_cap_irq: assert property (
      first_capture_irq |-> first_capture_flag && $past(global_irq_enable))
      else $error("capture irq without cause");
   a_cmpa_irq: assert property (
      first_compare_a_irq |->
         $past(first_compare_a_flag && global_irq_enable))
      else $error("compare a irq without cause");
   a_top_flag: assert property (
      counter_at_top[0] && capture_is_top[0] |=> first_capture_flag)
      else $error("flag not set at top");
   a_top_noload: assert property (
      capture_is_top[0] && $past(capture_is_top[0]) && !bus_wr |=>
         $stable(first_timer_capture_value))
      else $error("capture loaded in top mode");
   a_ack_clear: assert property (
      s_quiet ##0 (first_capture_irq_ack && !counter_at_top[0] &&
         !first_capture_src_comp) |=> !first_capture_flag)
      else $error("flag not cleared by ack");
   a_cap_latency: assert property (
      s_edge1 |-> ##[2:6] first_capture_flag)
      else $error("capture event lost");
endmodule // tcr_capture_compare_chk

`default_nettype wire

// >>> tcr_capture_compare_tb.sv
/*
 Self-checking bench for the capture/compare register slice.
 Assumes tcr_pkg and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tcr_capture_compare_tb;
   logic core_clk = 1'b0, srst = 1'b1;
   logic bus_io_space = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
   tcr_pkg::tcr_byte_t bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
   logic [1:0] capture_input_pin = 2'h0, capture_edge_rising = 2'h3;
   logic [1:0] capture_is_top = 2'h0, counter_at_top = 2'h0;
   logic analog_comp_out = 1'b0, first_capture_src_comp = 1'b0;
   logic global_irq_enable = 1'b0, first_capture_irq_ack = 1'b0;
   logic first_compare_a_flag = 1'b0, first_compare_b_flag = 1'b0;
   logic first_overflow_flag = 1'b0, first_capture_flag, first_capture_irq;
   logic first_compare_a_irq, first_compare_b_irq, first_overflow_irq;
   tcr_pkg::tcr_word_t first_running_counter_value = 16'h0000;
   tcr_pkg::tcr_word_t second_running_counter_value = 16'h0000;
   tcr_pkg::tcr_word_t first_timer_capture_value, second_timer_capture_value;
   tcr_pkg::tcr_word_t second_timer_compare_a, second_timer_compare_b;
   tcr_pkg::tcr_word_t second_timer_compare_c;
   int err_total = 0, n_tests = 0;
   localparam logic [7:0] lo_addr [5] = '{8'h46, 8'h80, 8'h82, 8'h84, 8'h86};
   wire logic [3:0] irqs = {first_capture_irq, first_compare_a_irq,
      first_compare_b_irq, first_overflow_irq};

   tcr_capture_compare dut (.*);

   always #50 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] pat(input int i);
      return 16'h1357 + 16'(i) * 16'h2468;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Strobe left high so a following wr makes a back-to-back pair
   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      @(negedge core_clk);
      bus_addr = a;
      bus_io_space = io;
      bus_wdata = d;
      bus_wr = 1'b1;
   endtask
   task automatic rel();
      @(negedge core_clk);
      bus_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic io, input logic [15:0] e);
      @(negedge core_clk);
      bus_addr = a;
      bus_io_space = io;
      bus_rd = 1'b1;
      @(negedge core_clk);
      bus_rd = 1'b0;
      chk(bus_rdata, e);
   endtask
   task automatic wr16(input logic [7:0] a, input logic io, input logic [15:0] v);
      wr(8'(a + 8'h01), io, v[15:8]);
      wr(a, io, v[7:0]);
      rel();
   endtask
   task automatic rd16(input logic [7:0] a, input logic io, input logic [15:0] v);
      rd(a, io, v & 16'h00FF);
      rd(8'(a + 8'h01), io, v >> 8);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 5; i++)
         rd16(lo_addr[i], 1'b0, 16'h0000);
      rd(8'h57, 1'b0, 8'h00);
      chk(first_capture_flag, 1'b0);
   endtask
   task automatic t_rw();
      for (int i = 0; i < 5; i++)
         wr16(lo_addr[i], 1'b0, pat(i));
      for (int i = 0; i < 5; i++)
         rd16(lo_addr[i], 1'b0, pat(i));
      chk(first_timer_capture_value, pat(0));
      chk(second_timer_capture_value, pat(1));
      chk(second_timer_compare_c, pat(2));
      chk(second_timer_compare_b, pat(3));
      chk(second_timer_compare_a, pat(4));
      rd16(8'h26, 1'b1, pat(0));
      wr16(8'h26, 1'b1, 16'hC0DE);
      rd16(8'h46, 1'b0, 16'hC0DE);
   endtask
   task automatic t_refuse();
      wr16(8'h86, 1'b1, 16'hFFFF);
      chk(second_timer_compare_a, pat(4));
      rd(8'h46, 1'b1, 8'h00);
      rd(8'h57, 1'b1, 8'h00);
      rd(8'h60, 1'b0, 8'h00);
   endtask
   task automatic t_latch();
      rd(8'h86, 1'b0, pat(4) & 16'h00FF);
      rd(8'h84, 1'b0, pat(3) & 16'h00FF);
      rd(8'h87, 1'b0, pat(3) >> 8);
      wr(8'h87, 1'b0, 8'hAB);
      wr(8'h80, 1'b0, 8'hCD);
      rel();
      chk(second_timer_capture_value, 16'hABCD);
      chk(second_timer_compare_a, pat(4));
   endtask
   task automatic t_capture();
      first_running_counter_value = 16'h4321;
      second_running_counter_value = 16'h8765;
      capture_edge_rising[1] = 1'b0;
      capture_input_pin = 2'h3;
      cyc(6);
      chk(first_timer_capture_value, 16'h4321);
      chk(second_timer_capture_value, 16'hABCD);
      chk(first_capture_flag, 1'b1);
      capture_input_pin[1] = 1'b0;
      cyc(6);
      chk(second_timer_capture_value, 16'h8765);
      rd16(8'h46, 1'b0, 16'h4321);
      // Source switch may fire once; counter held so it is harmless
      first_capture_src_comp = 1'b1;
      cyc(6);
      first_running_counter_value = 16'h0F0F;
      capture_input_pin[0] = 1'b0;
      cyc(3);
      capture_input_pin[0] = 1'b1;
      cyc(6);
      chk(first_timer_capture_value, 16'h4321);
      analog_comp_out = 1'b1;
      cyc(6);
      chk(first_timer_capture_value, 16'h0F0F);
      first_capture_src_comp = 1'b0;
      cyc(6);
      // Second timer in top mode keeps its value on pin events
      capture_is_top[1] = 1'b1;
      second_running_counter_value = 16'h2222;
      capture_input_pin[1] = 1'b1;
      cyc(3);
      capture_input_pin[1] = 1'b0;
      cyc(6);
      chk(second_timer_capture_value, 16'h8765);
      capture_is_top[1] = 1'b0;
      cyc(2);
   endtask
   task automatic t_irq();
      wr(8'h57, 1'b0, 8'hFF);
      rel();
      rd(8'h57, 1'b0, 8'h3C);
      first_compare_a_flag = 1'b1;
      first_compare_b_flag = 1'b1;
      first_overflow_flag = 1'b1;
      cyc(2);
      chk(irqs, 4'h0);
      global_irq_enable = 1'b1;
      cyc(2);
      chk(irqs, 4'hF);
      wr(8'h37, 1'b1, 8'h24);
      rel();
      cyc(1);
      chk(irqs, 4'h9);
   endtask
   task automatic t_clear();
      first_capture_irq_ack = 1'b1;
      @(negedge core_clk);
      first_capture_irq_ack = 1'b0;
      cyc(1);
      chk({first_capture_flag, first_capture_irq}, 2'h0);
      capture_is_top[0] = 1'b1;
      cyc(2);
      counter_at_top[0] = 1'b1;
      @(negedge core_clk);
      counter_at_top[0] = 1'b0;
      chk(first_capture_flag, 1'b1);
      wr(8'h56, 1'b0, 8'h20);
      rel();
      chk(first_capture_flag, 1'b0);
      first_running_counter_value = 16'h1111;
      capture_input_pin[0] = 1'b0;
      cyc(3);
      capture_input_pin[0] = 1'b1;
      cyc(6);
      chk(first_timer_capture_value, 16'h0F0F);
      chk(first_capture_flag, 1'b0);
      wr16(8'h46, 1'b0, 16'h00FF);
      chk(first_timer_capture_value, 16'h00FF);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      cyc(12);
      srst = 1'b0;
      cyc(1);
      t_reset();
      t_rw();
      t_refuse();
      t_latch();
      t_capture();
      t_irq();
      t_clear();
      print_verdict();
   end
endmodule // tcr_capture_compare_tb

bind tcr_capture_compare tcr_capture_compare_chk #(.TIMER_W(TIMER_W)) u_chk (.*);

`default_nettype wire
